// *** hdl/pfs_pkg.sv ***
// register map, field layout and bus constants of the line-unit / framing status bank
// assumes a 32-bit AHB-Lite slave port, one aligned word per register
package pfs_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] PFS_IDX_LINE_STATUS = 8'h48;
  localparam logic [7:0] PFS_IDX_PROG_DIR = 8'h4C;
  localparam logic [7:0] PFS_IDX_TRIB_SEL = 8'h4D;
  localparam logic [7:0] PFS_IDX_E1_FRM_ENA = 8'h4E;
  localparam logic [7:0] PFS_IDX_E3_STATUS = 8'h4F;
  localparam logic [7:0] PFS_IDX_E2_STAT_FIRST = 8'h50;
  localparam logic [7:0] PFS_IDX_E2_STAT_LAST = 8'h53;
  localparam logic [7:0] PFS_IDX_E1_STAT_FIRST = 8'h54;
  localparam logic [7:0] PFS_IDX_E1_STAT_LAST = 8'h57;
  localparam logic [7:0] PFS_IDX_DMA_MAP_FIRST = 8'h60;
  localparam logic [7:0] PFS_IDX_DMA_MAP_LAST = 8'h6F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PFS_BIT_PROG_SELECT = 7;
  localparam int PFS_BIT_PROG_CLOCK = 6;
  localparam int PFS_BIT_PROG_DATA_IN = 5;
  localparam int PFS_BIT_RESET_RELEASE = 4;
  localparam int PFS_BIT_PROG_DATA_OUT = 4;
  localparam int PFS_E2_SEL_LSB = 4;
  localparam int PFS_E2_SEL_W = 2;
  localparam int PFS_E1_SEL_W = 4;
  localparam int PFS_E2_STAT_W = 3;
  localparam int PFS_E1_STAT_W = 2;
  localparam int PFS_E1_ENA_W = 5;
  localparam int PFS_DMA_CODE_W = 5;
  localparam int PFS_E3_CH = 4;

  // ----------------------------------------------------------------
  // reset values and bus encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] PFS_RST_PROG_DIR = 8'h00;
  localparam logic [5:0] PFS_RST_TRIB_SEL = 6'h00;
  localparam logic [4:0] PFS_RST_E1_FRM_ENA = 5'h00;
  localparam logic [4:0] PFS_RST_DMA_CODE = 5'h00;
  localparam logic [31:0] PFS_ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] PFS_HRESP_OKAY = 2'h0;

  typedef enum logic {PFS_BUS_IDLE, PFS_BUS_RD_WAIT} pfs_bus_state_t;

endpackage

// *** hdl/pfs_reg_bank.sv ***
// register bank: line-unit programming pins, channel direction, tributary status, dma source map
// assumes AHB-Lite master with one slave; framer status inputs are on hclk, pin inputs are not
//
// Summary of operation
// - select pin follows control bit 7
// - programming clock pin follows control bit 6
// - programming data pin follows control bit 5
// - line unit held reset while bit 4 zero
// - bits 3-0 set channel transmit direction
// - bits 5-4 pick reported E2 tributary
// - bits 3-0 pick reported E1 tributary
// - enable bit limits channel to framed E1
// - bit 4 all-E1 channel, 0-3 per E3
// - alarm bits need framing and alarm both
// - low bits show E3 frame lock
// - four E2 status words, channels 0-3
// - E2 bit 2 shows far-end alarm
// - E2 bit 1 shows possible byte alignment
// - E2 bit 0 shows frame lock
// - four E1 status words, channels 0-3
// - E1 bit 1 shows possible byte alignment
// - E1 bit 0 shows frame lock
// - sixteen source maps, one per dma channel
// - five-bit source code, upper bits unused
// - codes map E1, differential, E3 inputs
// - line-unit serial output readable at bit 4
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pfs_reg_bank #(
  parameter int ADDR_W = 12,
  parameter int N_DMA = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  output logic line_unit_prog_select,
  output logic line_unit_prog_clock,
  output logic line_unit_prog_data_in,
  output logic line_unit_reset_release,
  output logic [3:0] channel_pair_transmit_dir,
  output logic [4:0] framed_e1_only_en,
  output logic [N_DMA*5-1:0] dma_source_code,
  input wire logic line_unit_prog_data_out,
  input wire logic [3:0] line_unit_loss,
  input wire logic [3:0] e3_frame_locked,
  input wire logic [3:0] e3_alarm_indication,
  input wire logic [4*4*3-1:0] e2_stat_all,
  input wire logic [4*16*2-1:0] e1_stat_all
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] w;
    w = a[ADDR_W-1:2];
    word_index = (w > (ADDR_W-2)'(8'hFF)) ? 8'hFF : 8'(w);
  endfunction

  function automatic logic in_range(input logic [7:0] i, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (i >= lo) && (i <= hi);
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] prog_dir_r;
  logic [5:0] trib_sel_r;
  logic [4:0] e1_frm_ena_r;
  logic [4:0] dma_map_r [N_DMA];
  logic [4:0] prog_out_sync_r;
  logic [4:0] prog_out_meta_r;
  pfs_pkg::pfs_bus_state_t bus_state_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [7:0] rd_idx_r;
  logic [7:0] rd_val;
  logic addr_phase;

  pfs_trib_if #(.N_CH(pfs_pkg::PFS_E3_CH)) trib ();

  assign trib.e2_tributary_select = trib_sel_r[pfs_pkg::PFS_E2_SEL_LSB +: pfs_pkg::PFS_E2_SEL_W];
  assign trib.e1_tributary_select = trib_sel_r[pfs_pkg::PFS_E1_SEL_W-1:0];

  pfs_trib_mux #(.N_CH(pfs_pkg::PFS_E3_CH)) u_trib_mux (
    .hclk(hclk),
    .hresetn(hresetn),
    .trib(trib.sel),
    .e2_stat_all(e2_stat_all),
    .e1_stat_all(e1_stat_all)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // serial output and loss pins are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_out_meta_r <= 5'h00;
      prog_out_sync_r <= 5'h00;
    end else begin
      prog_out_meta_r <= {line_unit_prog_data_out, line_unit_loss};
      prog_out_sync_r <= prog_out_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // bus protocol
  // ----------------------------------------------------------------
  assign addr_phase = hsel && htrans[1] && hready;

  // reads take one wait state so that a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_r <= pfs_pkg::PFS_BUS_IDLE;
      hreadyout <= 1'b1;
      hrdata <= pfs_pkg::PFS_ZERO_WORD;
      rd_idx_r <= 8'h00;
    end else begin
      case (bus_state_r)
        pfs_pkg::PFS_BUS_IDLE: begin
          if (addr_phase && !hwrite) begin
            bus_state_r <= pfs_pkg::PFS_BUS_RD_WAIT;
            rd_idx_r <= word_index(haddr);
            hreadyout <= 1'b0;
          end
        end
        pfs_pkg::PFS_BUS_RD_WAIT: begin
          bus_state_r <= pfs_pkg::PFS_BUS_IDLE;
          hrdata <= {24'h000000, rd_val};
          hreadyout <= 1'b1;
        end
        default: begin
          bus_state_r <= pfs_pkg::PFS_BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= pfs_pkg::PFS_HRESP_OKAY;
    end else begin
      hresp <= pfs_pkg::PFS_HRESP_OKAY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase && hwrite) begin
        wr_idx_r <= word_index(haddr);
      end
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_dir_r <= pfs_pkg::PFS_RST_PROG_DIR;
    end else if (wr_pend_r && wr_idx_r == pfs_pkg::PFS_IDX_PROG_DIR) begin
      prog_dir_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trib_sel_r <= pfs_pkg::PFS_RST_TRIB_SEL;
    end else if (wr_pend_r && wr_idx_r == pfs_pkg::PFS_IDX_TRIB_SEL) begin
      trib_sel_r <= hwdata[5:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      e1_frm_ena_r <= pfs_pkg::PFS_RST_E1_FRM_ENA;
    end else if (wr_pend_r && wr_idx_r == pfs_pkg::PFS_IDX_E1_FRM_ENA) begin
      e1_frm_ena_r <= hwdata[pfs_pkg::PFS_E1_ENA_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N_DMA; i++) begin
        dma_map_r[i] <= pfs_pkg::PFS_RST_DMA_CODE;
      end
    end else if (wr_pend_r && in_range(wr_idx_r, pfs_pkg::PFS_IDX_DMA_MAP_FIRST, pfs_pkg::PFS_IDX_DMA_MAP_LAST)) begin
      dma_map_r[4'(wr_idx_r - pfs_pkg::PFS_IDX_DMA_MAP_FIRST)] <= hwdata[pfs_pkg::PFS_DMA_CODE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs taken straight from the control flops
  // ----------------------------------------------------------------
  assign line_unit_prog_select = prog_dir_r[pfs_pkg::PFS_BIT_PROG_SELECT];
  assign line_unit_prog_clock = prog_dir_r[pfs_pkg::PFS_BIT_PROG_CLOCK];
  assign line_unit_prog_data_in = prog_dir_r[pfs_pkg::PFS_BIT_PROG_DATA_IN];
  // low on this pin keeps the line unit in reset
  assign line_unit_reset_release = prog_dir_r[pfs_pkg::PFS_BIT_RESET_RELEASE];
  assign channel_pair_transmit_dir = prog_dir_r[3:0];
  // bit 4 covers the pooled E1 channel, bits 3-0 the E1s inside each E3
  assign framed_e1_only_en = e1_frm_ena_r;

  // code decoding into E1, differential and E3 sources is done by the datapath
  always_comb begin
    for (int i = 0; i < N_DMA; i++) begin
      dma_source_code[i*5 +: 5] = dma_map_r[i];
    end
  end

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    if (rd_idx_r == pfs_pkg::PFS_IDX_LINE_STATUS) begin
      rd_val = {3'h0, prog_out_sync_r};
    end else if (rd_idx_r == pfs_pkg::PFS_IDX_PROG_DIR) begin
      rd_val = prog_dir_r;
    end else if (rd_idx_r == pfs_pkg::PFS_IDX_TRIB_SEL) begin
      rd_val = {2'h0, trib_sel_r};
    end else if (rd_idx_r == pfs_pkg::PFS_IDX_E1_FRM_ENA) begin
      rd_val = {3'h0, e1_frm_ena_r};
    end else if (rd_idx_r == pfs_pkg::PFS_IDX_E3_STATUS) begin
      rd_val = {e3_frame_locked & e3_alarm_indication, e3_frame_locked};
    end else if (in_range(rd_idx_r, pfs_pkg::PFS_IDX_E2_STAT_FIRST, pfs_pkg::PFS_IDX_E2_STAT_LAST)) begin
      // bit 2 far-end alarm, bit 1 alignment, bit 0 frame lock
      rd_val = {5'h00, trib.e2_sel_stat[int'(2'(rd_idx_r - pfs_pkg::PFS_IDX_E2_STAT_FIRST))*3 +: 3]};
    end else if (in_range(rd_idx_r, pfs_pkg::PFS_IDX_E1_STAT_FIRST, pfs_pkg::PFS_IDX_E1_STAT_LAST)) begin
      rd_val = {6'h00, trib.e1_sel_stat[int'(2'(rd_idx_r - pfs_pkg::PFS_IDX_E1_STAT_FIRST))*2 +: 2]};
    end else if (in_range(rd_idx_r, pfs_pkg::PFS_IDX_DMA_MAP_FIRST, pfs_pkg::PFS_IDX_DMA_MAP_LAST)) begin
      rd_val = {3'h0, dma_map_r[4'(rd_idx_r - pfs_pkg::PFS_IDX_DMA_MAP_FIRST)]};
    end
  end

endmodule
`default_nettype wire

// *** hdl/pfs_trib_if.sv ***
// selection fields and selected tributary status passed between bank and selector
// assumes both ends run on the bank clock
`timescale 1ns/10ps
`default_nettype none
interface pfs_trib_if #(parameter int N_CH = 4);
  logic [1:0] e2_tributary_select;
  logic [3:0] e1_tributary_select;
  logic [N_CH*3-1:0] e2_sel_stat;
  logic [N_CH*2-1:0] e1_sel_stat;
  modport bank (output e2_tributary_select, output e1_tributary_select, input e2_sel_stat, input e1_sel_stat);
  modport sel (input e2_tributary_select, input e1_tributary_select, output e2_sel_stat, output e1_sel_stat);
endinterface
`default_nettype wire

// *** hdl/pfs_trib_mux.sv ***
// picks the chosen E2 and E1 tributary status of every E3 channel
// assumes raw framer status on the same clock; result is registered
`timescale 1ns/10ps
`default_nettype none
module pfs_trib_mux #(
  parameter int N_CH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  pfs_trib_if.sel trib,
  input wire logic [N_CH*4*3-1:0] e2_stat_all,
  input wire logic [N_CH*16*2-1:0] e1_stat_all
);
  // ----------------------------------------------------------------
  // per-channel selection
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trib.e2_sel_stat <= '0;
      trib.e1_sel_stat <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        trib.e2_sel_stat[c*3 +: 3] <= e2_stat_all[(c*4 + int'(trib.e2_tributary_select))*3 +: 3];
        trib.e1_sel_stat[c*2 +: 2] <= e1_stat_all[(c*16 + int'(trib.e1_tributary_select))*2 +: 2];
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/pdh_liu_frame_status_dma_map_test.sv ***
// self-checking bench of the register bank
// assumes one bus master and the line unit model on the pins
`timescale 1ns/10ps
`default_nettype none
module pdh_liu_frame_status_dma_map_test;
  typedef struct packed {logic [7:0] idx; logic [31:0] wd; logic [7:0] rd;} pfs_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, sel, sck, sdi, rel, sdo;
  logic [11:0] haddr;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [3:0] dir, loss, lock, ai;
  logic [4:0] fen;
  logic [79:0] dma;
  logic [47:0] e2s;
  logic [127:0] e1s;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  wire hready = hreadyout;
  pfs_row_t rows [6] = '{'{8'h4C, 32'hFFFF_FFFF, 8'hFF}, '{8'h4C, 32'h0000_0035, 8'h35},
    '{8'h4D, 32'hFFFF_FFFF, 8'h3F}, '{8'h4E, 32'hFFFF_FFFF, 8'h1F},
    '{8'h4F, 32'h0000_00FF, 8'h00}, '{8'h5A, 32'h0000_00FF, 8'h00}};
  pfs_reg_bank #(.ADDR_W(12), .N_DMA(16)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_unit_prog_select(sel),
    .line_unit_prog_clock(sck), .line_unit_prog_data_in(sdi), .line_unit_reset_release(rel),
    .channel_pair_transmit_dir(dir), .framed_e1_only_en(fen), .dma_source_code(dma),
    .line_unit_prog_data_out(sdo), .line_unit_loss(loss), .e3_frame_locked(lock),
    .e3_alarm_indication(ai), .e2_stat_all(e2s), .e1_stat_all(e1s));
  pfs_line_unit_model lum_u (.sel(sel), .sclk(sck), .sdi(sdi), .rst_n(rel), .sdo(sdo));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // called just after a rising edge; holds each phase until hready is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] rd);
    haddr <= {2'b00, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic bang(input logic [7:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      for (int k = 0; k < 3; k++) begin
        xfer(1'b1, 8'h4C, {24'h000000, 1'b1, k == 1, v[i], 1'b1, 4'h0}, q);
      end
    end
  endtask
  task automatic rst_chk;
    chk("ctl pins", 32'({sel, sck, sdi, rel, dir}), 32'h0);
    xfer(1'b0, 8'h4D, 32'h0, q);
    chk("select reset", q, 32'h0);
    chk("e1 framed reset", 32'(fen), 32'h0);
    // all 80 code bits folded so that none of them escapes the compare
    chk("dma reset", {31'h0000_0000, |dma}, 32'h0);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // stuck handshake ends the run as a failure
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, loss, lock, ai, e2s, e1s} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rst_chk();
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].idx, rows[i].wd, q);
      xfer(1'b0, rows[i].idx, 32'h0, q);
      chk("readback", q, {24'h000000, rows[i].rd});
      chk("bus response", 32'(hresp), 32'h0);
      if (rows[i].idx == 8'h4C) chk("ctl pins", 32'({sel, sck, sdi, rel, dir}), 32'(rows[i].rd));
      if (rows[i].idx == 8'h4E) chk("e1 framed", 32'(fen), 32'(rows[i].rd));
    end
    // every one of the 32 codes once, then a write with only unused bits set
    for (int c = 0; c < 33; c++) begin
      xfer(1'b1, 8'h60 + 8'(c % 16), (c == 32) ? 32'h0000_00E0 : 32'(c), q);
      xfer(1'b0, 8'h60 + 8'(c % 16), 32'h0, q);
      chk("dma map", q, (c == 32) ? 32'h0 : 32'(c));
      chk("dma pin", 32'(dma[(c % 16)*5 +: 5]), (c == 32) ? 32'h0 : 32'(c));
    end
    lock <= 4'h5;
    ai <= 4'h3;
    loss <= 4'hA;
    for (int c = 0; c < 4; c++) begin
      for (int t = 0; t < 16; t++) begin
        if (t < 4) e2s[(c*4+t)*3 +: 3] <= (t == 2) ? 3'(c + 1) : 3'(6 - c);
        e1s[(c*16+t)*2 +: 2] <= (t == 9) ? 2'(c) : 2'(3 - c);
      end
    end
    xfer(1'b1, 8'h4D, 32'h0000_0029, q);
    repeat (3) @(posedge hclk);
    xfer(1'b0, 8'h4F, 32'h0, q);
    chk("e3 status", q, 32'h15);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b0, 8'h50 + 8'(c), 32'h0, q);
      chk("e2 status", q, 32'(c + 1));
      xfer(1'b0, 8'h54 + 8'(c), 32'h0, q);
      chk("e1 status", q, 32'(c));
    end
    bang(8'hA5, 8);
    repeat (4) @(posedge hclk);
    xfer(1'b0, 8'h48, 32'h0, q);
    chk("serial out high", q, 32'h1A);
    bang(8'h00, 1);
    repeat (4) @(posedge hclk);
    xfer(1'b0, 8'h48, 32'h0, q);
    chk("serial out low", q, 32'h0A);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rst_chk();
    end_sim();
  end
endmodule
bind pfs_reg_bank pfs_reg_bank_sva #(.ADDR_W(ADDR_W), .N_DMA(N_DMA)) sva_u (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .line_unit_prog_select(line_unit_prog_select),
  .line_unit_prog_clock(line_unit_prog_clock), .line_unit_prog_data_in(line_unit_prog_data_in),
  .line_unit_reset_release(line_unit_reset_release), .channel_pair_transmit_dir(channel_pair_transmit_dir),
  .framed_e1_only_en(framed_e1_only_en), .dma_source_code(dma_source_code));
`default_nettype wire

// *** tb/pfs_line_unit_model.sv ***
// serial programming port of the line unit, behavioural
// assumes software bit-bangs select, clock and data
`timescale 1ns/10ps
`default_nettype none
module pfs_line_unit_model (
  input wire logic sel,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic rst_n,
  output logic sdo
);
  logic [7:0] sh_r;
  // shifts only while selected and out of reset
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= 8'h00;
    end else if (sel) begin
      sh_r <= {sh_r[6:0], sdi};
    end
  end
  // unselected output is not a held value, so show its inverse
  assign sdo = sel ? sh_r[7] : ~sh_r[7];
endmodule
`default_nettype wire

// *** tb/pfs_reg_bank_sva.sv ***
// port checker of the register bank
// assumes bind onto pfs_reg_bank, one bus slave
`timescale 1ns/10ps
`default_nettype none
module pfs_reg_bank_sva #(
  parameter int ADDR_W = 12,
  parameter int N_DMA = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic line_unit_prog_select,
  input wire logic line_unit_prog_clock,
  input wire logic line_unit_prog_data_in,
  input wire logic line_unit_reset_release,
  input wire logic [3:0] channel_pair_transmit_dir,
  input wire logic [4:0] framed_e1_only_en,
  input wire logic [N_DMA*5-1:0] dma_source_code
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------
  // data-phase tracker
  // ----------------
  logic wr_r;
  logic [9:0] idx_r;
  wire take = hsel & htrans[1] & hready;
  wire wr_done = wr_r & hready;
  wire ctl_wr = wr_done && idx_r == {2'b00, pfs_pkg::PFS_IDX_PROG_DIR};
  wire ena_wr = wr_done && idx_r == {2'b00, pfs_pkg::PFS_IDX_E1_FRM_ENA};
  wire dma_wr = wr_done && idx_r[9:4] == 6'h06;
  wire [7:0] ctl = {line_unit_prog_select, line_unit_prog_clock, line_unit_prog_data_in,
    line_unit_reset_release, channel_pair_transmit_dir};
  // stalled data phases keep their address, so only hready advances the tracker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      idx_r <= 10'h000;
    end else if (hready) begin
      wr_r <= take & hwrite;
      idx_r <= haddr[11:2];
    end
  end
  // ----------------
  // assertions
  // ----------------
  a_sel_pin_follows: assert property (ctl_wr |=> ctl[7] == $past(hwdata[7]))
    else $error("select pin wrong");
  a_clk_pin_follows: assert property (ctl_wr |=> ctl[6] == $past(hwdata[6]))
    else $error("clock pin wrong");
  a_din_pin_follows: assert property (ctl_wr |=> ctl[5] == $past(hwdata[5]))
    else $error("data pin wrong");
  a_reset_pin_follows: assert property (ctl_wr |=> ctl[4] == $past(hwdata[4]))
    else $error("reset pin wrong");
  a_dir_pins_follow: assert property (ctl_wr |=> ctl[3:0] == $past(hwdata[3:0]))
    else $error("direction pins wrong");
  a_ctl_pins_hold: assert property (!ctl_wr |=> $stable(ctl))
    else $error("control pins moved");
  a_e1_ena_follows: assert property (ena_wr |=> framed_e1_only_en == $past(hwdata[4:0]))
    else $error("framed enable wrong");
  a_dma_code_follows: assert property (dma_wr |=>
    dma_source_code[$past(idx_r[3:0])*5 +: 5] == $past(hwdata[4:0])) else $error("dma code wrong");
  a_read_one_wait: assert property (take & !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_rdata_upper_zero: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  c_ctl_write: cover property (ctl_wr);
  c_dma_write: cover property (dma_wr);
  c_read_done: cover property (take & !hwrite ##2 hreadyout);
endmodule
`default_nettype wire
